// >>> design/eeprom_pkg.sv
// Notes on behaviour
// [RULE1] store 2048 bytes, reachable only over the serial link
// [RULE2] separate 32-byte identity page, lockable so it only reads afterwards
// [RULE3] outgoing bits change on the falling serial clock edge
// [RULE4] instruction, address and data bits captured on the rising serial clock edge
// [RULE5] chip select high: deselected, output floats, standby unless write work pends
// [RULE6] chip select low: selected and in the active power state
// [RULE7] after power-up, nothing is decoded until chip select has gone high then low
// [RULE8] pause asserted: output floats, serial input and clock ignored, stays selected
// [RULE9] master pauses only while chip select is low
// [RULE10] write-protect low freezes the two block-protect bits
// [RULE11] master holds write-protect steady through every write instruction
// [RULE12] all bytes travel most significant bit first, both directions
// [RULE13] first input bit taken on first rising edge after chip select falls
// [RULE14] first output bit on first falling edge after the last instruction bit; here the reply byte starts a byte or two later, idle bytes come first
// [RULE15] works in clock modes 0/0 and 1/1; sample rising, drive falling
// [RULE16] master idles the clock low in mode 0, high in mode 3
// [RULE17] master enters pause only while the serial clock is low
// [RULE18] deselect during pause resets logic except write-enable and busy bits
// [RULE19] master leaves pause only while the serial clock is low
package eeprom_pkg;
  // ----------------------------------------
  // storage geometry
  // ----------------------------------------
  localparam int MEM_BYTES = 2048;
  localparam int ID_BYTES = 32;
  localparam int ADDR_W = 11;
  localparam int ID_ADDR_W = 5;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_WIDTH = 9;
  localparam int BITS_PER_BYTE = 8;

  // ----------------------------------------
  // instruction codes
  // ----------------------------------------
  localparam logic [7:0] OP_WR_ENABLE = 8'h06;
  localparam logic [7:0] OP_WR_DISABLE = 8'h04;
  localparam logic [7:0] OP_RD_STATUS = 8'h05;
  localparam logic [7:0] OP_WR_STATUS = 8'h01;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_WRITE = 8'h02;
  localparam logic [7:0] OP_ID_READ = 8'h83;
  localparam logic [7:0] OP_ID_WRITE = 8'h82;
  localparam logic [7:0] OP_ID_LOCK = 8'h84;

  // ----------------------------------------
  // status layout and protected areas
  // ----------------------------------------
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_WEL_BIT = 1;
  localparam int ST_BP_LO_BIT = 2;
  localparam int ST_BP_HI_BIT = 3;
  localparam int ST_LOCK_BIT = 4;
  localparam logic [10:0] QUARTER_BASE = 11'h600;
  localparam logic [10:0] HALF_BASE = 11'h400;
  localparam logic [7:0] IDLE_TX = 8'hff;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [2:0] FIRST_BIT = 3'h0;

  typedef logic [7:0] byte_t;
  typedef enum logic [2:0] {
    S_IDLE,
    S_ADDR_HI,
    S_ADDR_LO,
    S_DATA,
    S_STATUS,
    S_WAIT
  } seq_t;
endpackage

// >>> design/fifo_if.sv
`timescale 1ns/1ns
interface fifo_if #(parameter int WIDTH = 9);
  logic wrValid;
  logic wrReady;
  logic [WIDTH-1:0] wrData;
  logic rdValid;
  logic rdReady;
  logic [WIDTH-1:0] rdData;
  modport store(input wrValid, input wrData, input rdReady,
    output wrReady, output rdValid, output rdData);
  modport fill(output wrValid, output wrData, input wrReady);
  modport drain(input rdValid, input rdData, output rdReady);
endinterface

// >>> design/async_fifo.sv
`timescale 1ns/1ns
module async_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input wire logic wrClock, // filling side clock
  input wire logic rdClock, // draining side clock
  input wire logic reset, // async, active high
  fifo_if.store port // both handshakes
);
  localparam int AW = $clog2(DEPTH);

  // ----------------------------------------
  // per-side pointer state
  // ----------------------------------------
  typedef struct packed {
    logic [AW:0] bin;
    logic [AW:0] gray;
    logic [AW:0] sync1;
    logic [AW:0] sync2;
  } side_t;

  side_t wq, wd, rq, rd;
  logic [WIDTH-1:0] mem [DEPTH];
  logic full;
  logic empty;
  logic [AW:0] wNext;
  logic [AW:0] rNext;

  // full compares against the far pointer with its two top bits inverted
  assign full = wq.gray == {~wq.sync2[AW:AW-1], wq.sync2[AW-2:0]};
  assign empty = rq.gray == rq.sync2;
  assign port.wrReady = !full;
  assign port.rdValid = !empty;
  assign port.rdData = mem[rq.bin[AW-1:0]];

  always_comb begin
    wd = wq;
    wNext = wq.bin + 1'b1;
    wd.sync1 = rq.gray;
    wd.sync2 = wq.sync1;
    if (port.wrValid && !full) begin
      wd.bin = wNext;
      wd.gray = wNext ^ (wNext >> 1);
    end
  end

  always_comb begin
    rd = rq;
    rNext = rq.bin + 1'b1;
    rd.sync1 = wq.gray;
    rd.sync2 = rq.sync1;
    if (port.rdReady && !empty) begin
      rd.bin = rNext;
      rd.gray = rNext ^ (rNext >> 1);
    end
  end

  always_ff @(posedge wrClock or posedge reset) begin
    if (reset) begin
      wq <= '0;
    end else begin
      wq <= wd;
    end
  end

  always_ff @(posedge wrClock) begin
    if (port.wrValid && !full) begin
      mem[wq.bin[AW-1:0]] <= port.wrData;
    end
  end

  always_ff @(posedge rdClock or posedge reset) begin
    if (reset) begin
      rq <= '0;
    end else begin
      rq <= rd;
    end
  end
endmodule

// >>> design/eeprom_spi_front_end.sv
`timescale 1ns/1ns
module eeprom_spi_front_end (
  input wire logic clock, // system clock, 25 MHz
  input wire logic reset, // async, active high
  input wire logic serialClock, // serial clock from the master
  input wire logic csN, // chip select, active low
  input wire logic dataIn, // serial data into the device
  output logic dataOut, // serial data out of the device
  output logic dataOutOe, // high while the device drives dataOut
  input wire logic holdN, // pause, active low
  input wire logic wpN, // write protect, active low
  output logic active, // selected, active power state
  output logic standby, // deselected with no work pending
  output logic overrun // sticky: a received byte was dropped
);
  import eeprom_pkg::*;

  // ----------------------------------------
  // state of the three clocking regions
  // ----------------------------------------
  typedef struct packed {
    logic [2:0] cnt;
    logic [6:0] shift;
    logic first;
    logic seenByte;
    logic dropped;
  } rx_t;

  typedef struct packed {
    logic req1;
    logic req2;
    logic ack;
    byte_t txShift;
  } tx_t;

  typedef struct packed {
    logic cs1;
    logic cs2;
    logic csPrev;
    logic [1:0] fill;
    logic wp1;
    logic wp2;
    logic ov1;
    logic ov2;
    logic ack1;
    logic ack2;
    logic armed;
    seq_t st;
    byte_t op;
    logic [ADDR_W-1:0] addr;
    logic wel;
    logic allowWr;
    logic [1:0] bp;
    logic idLock;
    byte_t txHold;
    byte_t nextTx;
    logic txReq;
    logic pend;
    logic active;
    logic standby;
    logic overrun;
  } sys_t;

  rx_t lq, ld;
  tx_t tq, td;
  sys_t q, d;
  logic oeQ;

  fifo_if #(.WIDTH(FIFO_WIDTH)) rxIf ();

  // ----------------------------------------
  // storage arrays
  // ----------------------------------------
  byte_t memArray [MEM_BYTES]; // [RULE1]
  byte_t idPage [ID_BYTES]; // [RULE2]
  logic memWe;
  logic idWe;
  byte_t wrByte;
  byte_t rxByte;
  logic rxFirst;
  logic [ADDR_W-1:0] addrInc;

  async_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) rxFifo (
    .wrClock(serialClock),
    .rdClock(clock),
    .reset(reset),
    .port(rxIf.store)
  );

  function automatic logic isProtected(input logic [ADDR_W-1:0] a, input logic [1:0] bp);
    logic hit;
    hit = 1'b0;
    unique case (bp)
      2'b00: hit = 1'b0;
      2'b01: hit = a >= QUARTER_BASE;
      2'b10: hit = a >= HALF_BASE;
      2'b11: hit = 1'b1;
    endcase
    return hit;
  endfunction

  // ----------------------------------------
  // link receive side, rising serial clock
  // ----------------------------------------
  // the byte is pushed on the very edge that completes it, because the
  // master may stop the clock right after the last bit of a frame
  always_comb begin
    ld = lq;
    rxIf.wrValid = 1'b0;
    rxIf.wrData = {lq.first, lq.shift, dataIn}; // [RULE12]
    if (holdN) begin // [RULE8]
      ld.shift = {lq.shift[5:0], dataIn}; // [RULE4] [RULE12]
      ld.cnt = lq.cnt + 3'h1;
      if (lq.cnt == LAST_BIT) begin
        rxIf.wrValid = 1'b1;
        ld.first = 1'b0;
        ld.seenByte = 1'b1;
        if (!rxIf.wrReady) begin
          ld.dropped = 1'b1;
        end
      end
    end
  end

  // deselect clears the bit position, also when it happens during a pause
  always_ff @(posedge serialClock or posedge csN or posedge reset) begin
    if (reset || csN) begin // [RULE13] [RULE18]
      lq <= '{cnt: FIRST_BIT, shift: '0, first: 1'b1, seenByte: 1'b0, dropped: 1'b0};
    end else begin
      lq <= ld;
    end
  end

  // ----------------------------------------
  // link transmit side, falling serial clock
  // ----------------------------------------
  // four-phase handshake, cleared by deselect, so a reply made for one
  // frame never leaks into the next; the holding register is stable
  // whenever the request is seen high
  always_comb begin
    td = tq;
    td.req1 = q.txReq;
    td.req2 = tq.req1;
    if (!tq.req2) begin
      td.ack = 1'b0;
    end
    if (holdN) begin // [RULE8]
      if (lq.cnt == FIRST_BIT) begin // [RULE14]
        if (tq.req2 && !tq.ack) begin
          td.txShift = q.txHold;
          td.ack = 1'b1;
        end else begin
          td.txShift = IDLE_TX;
        end
      end else begin
        td.txShift = {tq.txShift[6:0], 1'b1}; // [RULE3] [RULE12]
      end
    end
  end

  always_ff @(negedge serialClock or posedge csN or posedge reset) begin
    if (reset || csN) begin // [RULE5] [RULE18]
      tq <= '{req1: 1'b0, req2: 1'b0, ack: 1'b0, txShift: IDLE_TX};
    end else begin
      tq <= td; // [RULE15]
    end
  end

  // pause and deselect float the pin at once, without waiting for a clock
  always_ff @(negedge serialClock or posedge csN or negedge holdN or posedge reset) begin
    if (reset || csN || !holdN) begin // [RULE5] [RULE8]
      oeQ <= 1'b0;
    end else begin
      oeQ <= lq.seenByte; // [RULE14]
    end
  end

  assign dataOut = tq.txShift[7];
  assign dataOutOe = oeQ;

  // ----------------------------------------
  // system side: synchronisers and sequencer
  // ----------------------------------------
  assign rxByte = rxIf.rdData[7:0];
  assign rxFirst = rxIf.rdData[8];
  assign addrInc = q.addr + 11'h001;
  // draining stalls while a reply byte waits for the link, so a fast
  // master can fill the buffer and then loses bytes, flagged by overrun
  assign rxIf.rdReady = !q.pend;

  always_comb begin
    d = q;
    memWe = 1'b0;
    idWe = 1'b0;
    wrByte = rxByte;
    d.cs1 = csN;
    d.cs2 = q.cs1;
    // the chain holds reset values for two clocks; they must not pass for a
    // deselected pin, or a select held through reset would arm the device
    d.fill = {q.fill[0], 1'b1};
    d.csPrev = q.cs2 && q.fill[1];
    d.wp1 = wpN;
    d.wp2 = q.wp1;
    d.ov1 = lq.dropped;
    d.ov2 = q.ov1;
    d.ack1 = tq.ack;
    d.ack2 = q.ack1;
    if (q.csPrev && !q.cs2) begin
      d.armed = 1'b1; // [RULE7]
    end
    if (q.txReq && q.ack2) begin
      d.txReq = 1'b0;
    end else if (q.pend && !q.txReq && !q.ack2) begin
      d.txHold = q.nextTx;
      d.txReq = 1'b1;
      d.pend = 1'b0;
    end
    if (rxIf.rdValid && !q.pend) begin
      if (rxFirst) begin
        d.st = S_WAIT; // [RULE18]
        if (q.armed) begin // [RULE7]
          unique case (rxByte)
            OP_WR_ENABLE: d.wel = 1'b1;
            OP_WR_DISABLE: d.wel = 1'b0;
            OP_RD_STATUS: begin
              d.nextTx = '0;
              d.nextTx[ST_WEL_BIT] = q.wel;
              d.nextTx[ST_BP_LO_BIT] = q.bp[0];
              d.nextTx[ST_BP_HI_BIT] = q.bp[1];
              d.nextTx[ST_LOCK_BIT] = q.idLock;
              d.nextTx[ST_BUSY_BIT] = 1'b0;
              d.pend = 1'b1;
            end
            OP_WR_STATUS: begin
              d.allowWr = q.wel;
              d.wel = 1'b0;
              d.st = S_STATUS;
            end
            OP_READ, OP_ID_READ: begin
              d.op = rxByte;
              d.st = S_ADDR_HI;
            end
            OP_WRITE, OP_ID_WRITE: begin
              d.op = rxByte;
              d.allowWr = q.wel;
              d.wel = 1'b0;
              d.st = S_ADDR_HI;
            end
            OP_ID_LOCK: begin
              if (q.wel) begin
                d.idLock = 1'b1; // [RULE2]
              end
              d.wel = 1'b0;
            end
            default: d.st = S_WAIT;
          endcase
        end
      end else begin
        unique case (q.st)
          S_IDLE, S_WAIT: d.st = q.st;
          S_ADDR_HI: begin
            d.addr[10:8] = rxByte[2:0];
            d.st = S_ADDR_LO;
          end
          S_ADDR_LO: begin
            d.addr[7:0] = rxByte;
            d.st = S_DATA;
            if (q.op == OP_READ) begin
              d.nextTx = memArray[{q.addr[10:8], rxByte}];
              d.addr = {q.addr[10:8], rxByte} + 11'h001;
              d.pend = 1'b1;
            end else if (q.op == OP_ID_READ) begin
              d.nextTx = idPage[rxByte[4:0]];
              d.addr = {q.addr[10:8], rxByte} + 11'h001;
              d.pend = 1'b1;
            end
          end
          S_DATA: begin
            if (q.op == OP_READ) begin
              d.nextTx = memArray[q.addr];
              d.addr = addrInc;
              d.pend = 1'b1;
            end else if (q.op == OP_ID_READ) begin
              d.nextTx = idPage[q.addr[ID_ADDR_W-1:0]];
              d.addr = addrInc;
              d.pend = 1'b1;
            end else if (q.op == OP_WRITE) begin
              memWe = q.allowWr && !isProtected(q.addr, q.bp);
              d.addr = addrInc;
            end else begin
              idWe = q.allowWr && !q.idLock; // [RULE2]
              d.addr = addrInc;
            end
          end
          S_STATUS: begin
            // a low protect pin holds the protected area size as it is
            if (q.allowWr && q.wp2) begin // [RULE10]
              d.bp = {rxByte[ST_BP_HI_BIT], rxByte[ST_BP_LO_BIT]};
            end
            d.st = S_WAIT;
          end
        endcase
      end
    end
    // once deselect is seen, an unsent reply is dropped and a read still
    // draining its dummy bytes stops fetching
    if (q.cs2) begin
      d.pend = 1'b0;
      d.txReq = 1'b0;
      if (q.st == S_DATA && (q.op == OP_READ || q.op == OP_ID_READ)) begin
        d.st = S_WAIT;
      end
    end
    d.active = !q.cs2; // [RULE6]
    d.standby = q.cs2 && !rxIf.rdValid && !q.pend; // [RULE5]
    d.overrun = q.overrun || q.ov2;
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      q <= '0;
      q.cs1 <= 1'b1;
      q.cs2 <= 1'b1;
      q.wp1 <= 1'b1;
      q.wp2 <= 1'b1;
      q.standby <= 1'b1;
      q.st <= S_IDLE;
    end else begin
      q <= d;
    end
  end

  // arrays carry no reset, like the non-volatile cells they stand for
  always_ff @(posedge clock) begin
    if (memWe) begin
      memArray[q.addr] <= wrByte; // [RULE1]
    end
    if (idWe) begin
      idPage[q.addr[ID_ADDR_W-1:0]] <= wrByte;
    end
  end

  assign active = q.active;
  assign standby = q.standby;
  assign overrun = q.overrun;
endmodule

// >>> verif/eeprom_spi_chk.sv
`timescale 1ns/1ns
module eeprom_spi_chk (
  input wire logic clock, // system clock
  input wire logic reset, // async reset
  input wire logic serialClock, // link clock
  input wire logic csN, // chip select
  input wire logic dataOut, // link output
  input wire logic dataOutOe, // drive enable
  input wire logic holdN, // pause
  input wire logic active, // selected
  input wire logic standby, // idle
  input wire logic overrun // sticky drop
);
  logic [3:0] rises;
  // --
  // rises since select, frozen in pause
  // --
  always_ff @(posedge serialClock or posedge csN) begin
    if (csN) begin
      rises <= 4'h0;
    end else if (holdN && rises != 4'hf) begin
      rises <= rises + 4'h1;
    end
  end
  chk_oe_desel: assert property (
    @(posedge clock) disable iff (reset) csN |-> !dataOutOe)
    else $error("output driven while deselected");
  chk_oe_pause: assert property (
    @(posedge clock) disable iff (reset) !holdN |-> !dataOutOe)
    else $error("output driven in pause");
  chk_active_sel: assert property (
    @(posedge clock) disable iff (reset) $fell(csN) |-> ##[1:5] active)
    else $error("select did not raise active");
  chk_active_drop: assert property (
    @(posedge clock) disable iff (reset) $rose(csN) |-> ##[1:5] !active)
    else $error("deselect did not drop active");
  chk_mode_excl: assert property (
    @(posedge clock) disable iff (reset) active |-> !standby)
    else $error("active and standby together");
  chk_overrun_sticky: assert property (
    @(posedge clock) disable iff (reset) $rose(overrun) |=> overrun [*8])
    else $error("overrun flag fell");
  chk_oe_after_byte: assert property (
    @(negedge serialClock) disable iff (reset) dataOutOe |-> rises >= 4'h8)
    else $error("output driven before first byte");
  chk_pause_freeze: assert property (
    @(negedge serialClock) disable iff (reset)
    !csN && !holdN && $past(holdN) == 1'b0 |-> $stable(dataOut))
    else $error("output moved in pause");
  cov_overrun: cover property (@(posedge clock) $rose(overrun));
  cov_pause: cover property (@(posedge clock) !csN && !holdN);
  cov_reply: cover property (@(negedge serialClock) $rose(dataOutOe));
endmodule

// >>> verif/spi_master_model.sv
`timescale 1ns/1ns
module spi_master_model (
  output logic serialClock, // runs only inside frames
  output logic csN, // chip select
  output logic dataIn, // master to device
  output logic holdN, // pause
  input wire logic dataOut, // device to master
  input wire logic dataOutOe // device drive enable
);
  import eeprom_pkg::*;
  logic cpol;
  logic lastOut;
  logic miso;
  // --
  // a released line shows the inverse of its last level
  // --
  always @(negedge dataOutOe) begin
    lastOut = dataOut;
  end
  assign miso = dataOutOe ? dataOut : !lastOut;
  initial begin
    cpol = 1'b0;
    serialClock = 1'b0;
    csN = 1'b1;
    dataIn = 1'b0;
    holdN = 1'b1;
    lastOut = 1'b0;
  end
  task automatic select();
    #200;
    csN = 1'b0;
    #200;
  endtask
  task automatic deselect();
    #20;
    csN = 1'b1;
    #200;
  endtask
  task automatic setMode(input logic pol);
    cpol = pol;
    serialClock = pol;
  endtask
  task automatic xfer(input byte_t tx, output byte_t rx);
    for (int i = 7; i >= 0; i--) begin
      serialClock = 1'b0;
      dataIn = tx[i];
      #6;
      serialClock = 1'b1;
      rx[i] = miso;
      #6;
    end
    serialClock = cpol;
  endtask
  // garbage edges and data in pause must be ignored
  task automatic holdOn(input int edges);
    holdN = 1'b0;
    for (int i = 0; i < edges; i++) begin
      #6;
      serialClock = 1'b1;
      dataIn = !dataIn;
      #6;
      serialClock = 1'b0;
    end
    #6;
  endtask
  task automatic holdOff();
    holdN = 1'b1;
    #6;
  endtask
endmodule

// >>> verif/serial_eeprom_spi_front_end_test.sv
`timescale 1ns/1ns
module serial_eeprom_spi_front_end_test;
  import eeprom_pkg::*;
  logic clock;
  logic reset;
  logic wpN;
  wire serialClock, csN, dataIn, holdN, dataOut, dataOutOe, active, standby, overrun;
  int n_mismatch = 0;
  int total_checks = 0;
  eeprom_spi_front_end dut (.clock(clock), .reset(reset), .serialClock(serialClock),
    .csN(csN), .dataIn(dataIn), .dataOut(dataOut), .dataOutOe(dataOutOe), .holdN(holdN),
    .wpN(wpN), .active(active), .standby(standby), .overrun(overrun));
  spi_master_model mst (.serialClock(serialClock), .csN(csN), .dataIn(dataIn),
    .holdN(holdN), .dataOut(dataOut), .dataOutOe(dataOutOe));
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  task automatic check(input string what, input byte_t exp, input byte_t got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic send(input byte_t b[$]);
    byte_t rx;
    foreach (b[i]) begin
      mst.xfer(b[i], rx);
    end
  endtask
  task automatic sendFrame(input byte_t b[$]);
    mst.select();
    send(b);
    mst.deselect();
  endtask
  // --
  // replies lag by a byte or two, so idle bytes are skipped
  // --
  task automatic drain(input string what, input byte_t exp[$], input byte_t mask);
    byte_t rx;
    byte_t got[$];
    for (int i = 0; i < 16 && got.size() < exp.size(); i++) begin
      mst.xfer(IDLE_TX, rx);
      if (rx !== IDLE_TX) begin
        got.push_back(rx);
      end
    end
    mst.deselect();
    foreach (exp[i]) begin
      check(what, exp[i], got[i] & mask);
    end
  endtask
  task automatic expectRead(input string what, input byte_t h[$], input byte_t e[$],
    input byte_t mask);
    mst.select();
    send(h);
    drain(what, e, mask);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic testUnarmed();
    byte_t rx;
    repeat (3) @(negedge clock);
    mst.xfer(OP_RD_STATUS, rx);
    repeat (5) begin
      mst.xfer(IDLE_TX, rx);
      check("unarmed reply", IDLE_TX, rx);
    end
    mst.deselect();
    $display("unarmed done");
  endtask
  task automatic testSelect();
    mst.select();
    @(negedge clock);
    check("active", 8'h02, 8'({active, standby}));
    mst.deselect();
    @(negedge clock);
    check("standby", 8'h02, 8'({active, standby, dataOutOe}));
    $display("select done");
  endtask
  task automatic testReadWrite();
    sendFrame({OP_WR_ENABLE});
    sendFrame({OP_WR_STATUS, 8'h00});
    sendFrame({OP_WR_ENABLE});
    sendFrame({OP_WRITE, 8'h07, 8'hfe, 8'ha5, 8'h3c});
    expectRead("array", {OP_READ, 8'h07, 8'hfe}, {8'ha5, 8'h3c}, 8'hff);
    expectRead("wel clear", {OP_RD_STATUS}, {8'h00}, 8'h0f);
    sendFrame({OP_WR_ENABLE});
    sendFrame({OP_WR_DISABLE});
    sendFrame({OP_WRITE, 8'h07, 8'hfe, 8'h00});
    expectRead("disabled", {OP_READ, 8'h07, 8'hfe}, {8'ha5}, 8'hff);
    mst.setMode(1'b1);
    sendFrame({OP_WR_ENABLE});
    expectRead("mode3 status", {OP_RD_STATUS}, {8'h02}, 8'h0f);
    expectRead("mode3 array", {OP_READ, 8'h07, 8'hff}, {8'h3c}, 8'hff);
    mst.setMode(1'b0);
    $display("read write done");
  endtask
  task automatic testProtect();
    sendFrame({OP_WRITE, 8'h06, 8'h00, 8'h11});
    sendFrame({OP_WR_ENABLE});
    sendFrame({OP_WR_STATUS, 8'h04});
    sendFrame({OP_WR_ENABLE});
    sendFrame({OP_WRITE, 8'h06, 8'h00, 8'h22});
    expectRead("protected", {OP_READ, 8'h06, 8'h00}, {8'h11}, 8'hff);
    @(negedge clock);
    wpN = 1'b0;
    sendFrame({OP_WR_ENABLE});
    sendFrame({OP_WR_STATUS, 8'h00});
    expectRead("frozen", {OP_RD_STATUS}, {8'h04}, 8'h0c);
    @(negedge clock);
    wpN = 1'b1;
    sendFrame({OP_WR_ENABLE});
    sendFrame({OP_WR_STATUS, 8'h00});
    expectRead("unfrozen", {OP_RD_STATUS}, {8'h00}, 8'h0c);
    $display("protect done");
  endtask
  task automatic testHold();
    sendFrame({OP_WR_ENABLE});
    sendFrame({OP_WRITE, 8'h01, 8'h00, 8'h5a});
    mst.select();
    send({OP_READ, 8'h01});
    mst.holdOn(8);
    check("pause", 8'h02, 8'({active, dataOutOe}));
    mst.holdOff();
    send({8'h00});
    drain("after pause", {8'h5a}, 8'hff);
    mst.select();
    send({OP_READ});
    mst.holdOn(0);
    mst.deselect();
    mst.holdOff();
    expectRead("after abort", {OP_READ, 8'h01, 8'h00}, {8'h5a}, 8'hff);
    $display("hold done");
  endtask
  task automatic testIdPage();
    sendFrame({OP_WR_ENABLE});
    sendFrame({OP_ID_WRITE, 8'h00, 8'h1f, 8'hc3});
    expectRead("id page", {OP_ID_READ, 8'h00, 8'h1f}, {8'hc3}, 8'hff);
    sendFrame({OP_WR_ENABLE});
    sendFrame({OP_ID_LOCK});
    expectRead("lock", {OP_RD_STATUS}, {8'h10}, 8'h10);
    sendFrame({OP_WR_ENABLE});
    sendFrame({OP_ID_WRITE, 8'h00, 8'h1f, 8'h3c});
    expectRead("locked id", {OP_ID_READ, 8'h00, 8'h1f}, {8'hc3}, 8'hff);
    $display("id page done");
  endtask
  task automatic testOverrun();
    byte_t q[$];
    // each read reply stalls draining, so a long read overfills the buffer
    q = {OP_READ, 8'h07, 8'hfe};
    for (int i = 0; i < 80; i++) begin
      q.push_back(8'h01);
    end
    sendFrame({OP_WR_ENABLE});
    sendFrame(q);
    @(negedge clock);
    check("overrun", 8'h01, 8'(overrun));
    repeat (100) @(negedge clock);
    check("drained", 8'h01, 8'(standby));
    $display("overrun done");
  endtask
  initial begin
    reset = 1'b1;
    wpN = 1'b1;
    repeat (5) @(negedge clock);
    check("reset", 8'h02, 8'({dataOutOe, active, standby, overrun}));
    mst.csN = 1'b0;
    reset = 1'b0;
    testUnarmed();
    testSelect();
    testReadWrite();
    testProtect();
    testHold();
    testIdPage();
    testOverrun();
    summarize();
  end
  // the whole run takes well under 200 us
  initial begin
    #500000;
    n_mismatch++;
    summarize();
  end
endmodule
bind eeprom_spi_front_end eeprom_spi_chk chk (.clock(clock), .reset(reset),
  .serialClock(serialClock), .csN(csN), .dataOut(dataOut), .dataOutOe(dataOutOe),
  .holdN(holdN), .active(active), .standby(standby), .overrun(overrun));
